// file: src/dmd_defs.vh
// data memory map decoder constants: address layout, windows, timing
// assumes inclusion by the decoder and its storage module only
`ifndef DMD_DEFS_VH
`define DMD_DEFS_VH
`define DMD_ADDR_W        12
`define DMD_DATA_W        8
`define DMD_DEPTH         4096
`define DMD_RAM_BASE      12'h000
`define DMD_CTL_BASE      12'hF80
`define DMD_CTL_TOP       12'hFFF
`define DMD_IND_PLAIN     12'hFEF
`define DMD_IND_POSTINC   12'hFEE
`define DMD_IND_POSTDEC   12'hFED
`define DMD_IND_PREINC    12'hFEC
`define DMD_IND_PLUSW     12'hFEB
`define DMD_PTR_HI        12'hFEA
`define DMD_PTR_LO        12'hFE9
`define DMD_WREG          12'hFE8
`define DMD_GAP_0         12'hFD4
`define DMD_GAP_1         12'hFB9
`define DMD_GAP_2         12'hFAA
`define DMD_GAP_3         12'hF9C
`define DMD_GAP_4         12'hF9A
`define DMD_RUN0_LO       12'hF97
`define DMD_RUN0_HI       12'hF99
`define DMD_RUN1_LO       12'hF8E
`define DMD_RUN1_HI       12'hF91
`define DMD_RUN2_LO       12'hF85
`define DMD_RUN2_HI       12'hF88
`define DMD_RUN3_LO       12'hF78
`define DMD_RUN3_HI       12'hF7F
`define DMD_LARGE_0       12'hFBC
`define DMD_LARGE_1       12'hFBB
`define DMD_LARGE_2       12'hFBA
`define DMD_LARGE_3       12'hFB6
`define DMD_LARGE_4       12'hFB5
`define DMD_LARGE_5       12'hF96
`define DMD_LARGE_6       12'hF95
`define DMD_LARGE_7       12'hF8D
`define DMD_LARGE_8       12'hF8C
`define DMD_LARGE_9       12'hF83
`define DMD_READ_LAT      1
`endif

// file: src/dmd_ram.v
// scratch and control storage array with registered read data
// assumes one access per cycle from the decoder; contents never reset
`timescale 1ns/10ps
`include "dmd_defs.vh"
module dmd_ram #(
    parameter AW = 12,
    parameter DW = 8
) (
    input  wire          clk_i,
    input  wire          we_i,
    input  wire [AW-1:0] addr_i,
    input  wire [DW-1:0] wdata_i,
    output reg  [DW-1:0] rdata_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // plain storage: no reset or init, contents survive any reset
    always @(posedge clk_i)
    begin
        if (we_i)
            mem[addr_i] <= wdata_i;
        rdata_o <= mem[addr_i];
    end
endmodule

// file: src/dmd_decoder.v
// data memory map decoder: scratch area, control area, indirect ports
// assumes core drives one access per cycle synchronous to clk_i
`timescale 1ns/10ps
`include "dmd_defs.vh"
// Operation
// - scratch RAM fills upward from address zero
// - scratch RAM never cleared by any reset
// - control registers decode in F80h through FFFh
// - control registers live in RAM array cells, pointer and working register read from live copies
// - unused control locations read as zero
// - large-package-only registers read zero on small
// - indirect ports redirect access, hold no storage
// - 12-bit address, sixteen banks, F78h-F7Fh and control gaps unimplemented
// - unimplemented writes ignored, reads zero, flags okay
module dmd_decoder #(
    parameter AW         = 12,
    parameter DW         = 8,
    parameter LARGE_PKG  = 1,
    parameter RAM_TOP    = 12'hF7F
) (
    input  wire          clk_i,
    input  wire          nrst_i,
    input  wire          req_i,
    input  wire          we_i,
    input  wire [AW-1:0] addr_i,
    input  wire [DW-1:0] wdata_i,
    output reg           ack_o,
    output wire [DW-1:0] rdata_o,
    output reg           access_ok_o,
    output reg           is_ctl_o,
    output reg           redirect_o
);
    reg  [AW-1:0] ptr;
    reg  [DW-1:0] wreg;
    reg  [AW-1:0] eff_addr;
    reg  [AW-1:0] next_ptr;
    reg           ind;
    reg           ctl;
    reg           implemented;
    reg           mem_we;
    reg           zero_q;
    wire [DW-1:0] ram_q;
    reg           shadow_hit;
    reg           shadow_sel;
    reg  [DW-1:0] next_shadow;
    reg  [DW-1:0] shadow_q;

    // registers fitted only on the large package, empty on the small one
    function large_only;
        input [AW-1:0] a;
        begin
            large_only = 1'b0;
            if (a == `DMD_LARGE_0)
                large_only = 1'b1;
            else if (a == `DMD_LARGE_1)
                large_only = 1'b1;
            else if (a == `DMD_LARGE_2)
                large_only = 1'b1;
            else if (a == `DMD_LARGE_3)
                large_only = 1'b1;
            else if (a == `DMD_LARGE_4)
                large_only = 1'b1;
            else if (a == `DMD_LARGE_5)
                large_only = 1'b1;
            else if (a == `DMD_LARGE_6)
                large_only = 1'b1;
            else if (a == `DMD_LARGE_7)
                large_only = 1'b1;
            else if (a == `DMD_LARGE_8)
                large_only = 1'b1;
            else if (a == `DMD_LARGE_9)
                large_only = 1'b1;
        end
    endfunction

    // unimplemented control slots and the F78h-F7Fh run, plus large-only slots when small
    function slot_unused;
        input [AW-1:0] a;
        begin
            slot_unused = 1'b0;
            // lone empty slots inside the control area
            if (a == `DMD_GAP_0)
                slot_unused = 1'b1;
            else if (a == `DMD_GAP_1)
                slot_unused = 1'b1;
            else if (a == `DMD_GAP_2)
                slot_unused = 1'b1;
            else if (a == `DMD_GAP_3)
                slot_unused = 1'b1;
            else if (a == `DMD_GAP_4)
                slot_unused = 1'b1;
            // runs of empty slots, both ends included
            else if (a >= `DMD_RUN0_LO && a <= `DMD_RUN0_HI)
                slot_unused = 1'b1;
            else if (a >= `DMD_RUN1_LO && a <= `DMD_RUN1_HI)
                slot_unused = 1'b1;
            else if (a >= `DMD_RUN2_LO && a <= `DMD_RUN2_HI)
                slot_unused = 1'b1;
            // empty run just below the control area reads zero as well
            else if (a >= `DMD_RUN3_LO && a <= `DMD_RUN3_HI)
                slot_unused = 1'b1;
            // small package: large-only cells behave as empty slots
            else if (LARGE_PKG == 0)
                slot_unused = large_only(a);
        end
    endfunction

    // decode: indirect ports swap in the pointer address
    always @*
    begin
        ind      = 1'b0;
        eff_addr = addr_i;
        next_ptr = ptr;
        if (addr_i == `DMD_IND_PLAIN)
        begin
            ind = 1'b1;
            eff_addr = ptr;
        end
        else if (addr_i == `DMD_IND_POSTINC)
        begin
            ind = 1'b1;
            eff_addr = ptr;
            next_ptr = ptr + 12'h001;
        end
        else if (addr_i == `DMD_IND_POSTDEC)
        begin
            ind = 1'b1;
            eff_addr = ptr;
            next_ptr = ptr - 12'h001;
        end
        else if (addr_i == `DMD_IND_PREINC)
        begin
            ind = 1'b1;
            eff_addr = ptr + 12'h001;
            next_ptr = ptr + 12'h001;
        end
        else if (addr_i == `DMD_IND_PLUSW)
        begin
            ind = 1'b1;
            eff_addr = ptr + {{(AW-DW){wreg[DW-1]}}, wreg};
        end
        // control area is the top half of bank fifteen
        ctl = (eff_addr >= `DMD_CTL_BASE);
        // scratch runs from zero up to its top, below control area
        implemented = !slot_unused(eff_addr) &&
                      (ctl || (eff_addr <= RAM_TOP));
        // indirect at an indirect port itself reads zero, no write
        if (ind && (eff_addr >= `DMD_IND_PLUSW &&
                    eff_addr <= `DMD_IND_PLAIN))
            implemented = 1'b0;
        mem_we = req_i && we_i && implemented;
        // pointer and working cells answer from their live copies,
        // since indirect steps move the pointer without a RAM write
        shadow_hit  = 1'b1;
        next_shadow = wreg;
        if (eff_addr == `DMD_PTR_LO)
            next_shadow = ptr[DW-1:0];
        else if (eff_addr == `DMD_PTR_HI)
            next_shadow = {{(2*DW-AW){1'b0}}, ptr[AW-1:DW]};
        else if (eff_addr != `DMD_WREG)
            shadow_hit = 1'b0;
    end

    // pointer and working register shadows, updated by access
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ptr  <= 12'h000;
            wreg <= 8'h00;
        end
        else if (req_i)
        begin
            if (ind)
                ptr <= next_ptr;
            if (we_i && eff_addr == `DMD_PTR_LO)
                ptr <= {ptr[AW-1:DW], wdata_i};
            else if (we_i && eff_addr == `DMD_PTR_HI)
                ptr <= {wdata_i[AW-DW-1:0], ptr[DW-1:0]};
            if (we_i && eff_addr == `DMD_WREG)
                wreg <= wdata_i;
        end
    end

    // one-cycle registered answer
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ack_o       <= 1'b0;
            zero_q      <= 1'b1;
            access_ok_o <= 1'b0;
            is_ctl_o    <= 1'b0;
            redirect_o  <= 1'b0;
            shadow_sel  <= 1'b0;
            shadow_q    <= 8'h00;
        end
        else
        begin
            ack_o       <= req_i;
            zero_q      <= !implemented;
            access_ok_o <= req_i; // flags behave as success
            is_ctl_o    <= req_i && ctl;
            redirect_o  <= req_i && ind;
            shadow_sel  <= shadow_hit;
            shadow_q    <= next_shadow;
        end
    end

    assign rdata_o = zero_q ? 8'h00 : (shadow_sel ? shadow_q : ram_q);

    // one array holds scratch and control cells alike
    dmd_ram #(
        .AW (AW),
        .DW (DW)
    ) u_ram (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .addr_i  (eff_addr),
        .wdata_i (wdata_i),
        .rdata_o (ram_q)
    );
endmodule

// file: sim/dmd_assertions.sv
// checker for access answers and map decode of the decoder
// assumes a bind to the decoder top, one clock domain
`timescale 1ns/10ps
module dmd_checker (
    input wire        clk_i,
    input wire        nrst_i,
    input wire        req_i,
    input wire        we_i,
    input wire [11:0] addr_i,
    input wire [7:0]  rdata_o,
    input wire        ack_o,
    input wire        access_ok_o,
    input wire        is_ctl_o,
    input wire        redirect_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // indirect port window
    wire ind_hit = addr_i >= 12'hFEB && addr_i <= 12'hFEF;
    sequence s_unused_rd;
        req_i && !we_i && addr_i == 12'hF9C;
    endsequence
    sequence s_gap_rd;
        req_i && !we_i && addr_i >= 12'hF78 && addr_i <= 12'hF7F;
    endsequence
    ack_follow_a: assert property (req_i |=> ack_o)
        else $error("ack missing");
    ack_quiet_a: assert property (!req_i |=> !ack_o)
        else $error("stray ack");
    ok_always_a: assert property (ack_o |-> access_ok_o)
        else $error("ok low");
    ctl_decode_a: assert property
        (req_i && addr_i >= 12'hF80 && !ind_hit |=> is_ctl_o)
        else $error("ctl missed");
    ram_decode_a: assert property (req_i && addr_i < 12'hF80
        |=> !is_ctl_o && !redirect_o) else $error("ram miscoded");
    redir_hit_a: assert property (req_i && ind_hit |=> redirect_o)
        else $error("no redirect");
    redir_quiet_a: assert property
        (req_i && !ind_hit |=> !redirect_o)
        else $error("stray redirect");
    unused_zero_a: assert property
        (s_unused_rd |=> rdata_o == 8'h00)
        else $error("unused not zero");
    gap_zero_a: assert property (s_gap_rd |=> rdata_o == 8'h00)
        else $error("gap not zero");
endmodule

// file: sim/dmd_core_model.sv
// core-side data bus model, one access per call
// assumes the decoder answers one cycle after each request
`timescale 1ns/10ps
module dmd_core (
    input  wire        clk_i,
    output reg         req_o,
    output reg         we_o,
    output reg  [11:0] addr_o,
    output reg  [7:0]  wdata_o
);
    initial {req_o, we_o, addr_o, wdata_o} = 22'h0;
    // drive at falling edge, drop after the taking edge
    task acc(input w, input [11:0] a, input [7:0] d);
    begin
        @(negedge clk_i);
        {req_o, we_o, addr_o, wdata_o} = {1'b1, w, a, d};
        @(negedge clk_i);
        req_o = 1'b0;
        addr_o = ~a; // no stale address once idle
    end
    endtask
endmodule

// file: sim/test_data_memory_map_decoder.sv
// self-checking bench for the data memory map decoder
// assumes the core model drives the request side
`timescale 1ns/10ps
module test_data_memory_map_decoder;
    reg         clk_i = 1'b0;
    reg         nrst_i = 1'b0;
    wire        req;
    wire        we;
    wire [11:0] addr;
    wire [7:0]  wdata;
    wire [7:0]  rdata;
    wire        ack;
    wire        ok;
    wire        ctl;
    wire        redir;
    wire [7:0]  rdata_s;
    integer     err_count = 0;
    integer     samples_checked = 0;
    always #10 clk_i = ~clk_i;
    dmd_core u_core (.clk_i(clk_i), .req_o(req), .we_o(we),
        .addr_o(addr), .wdata_o(wdata));
    dmd_decoder dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req),
        .we_i(we), .addr_i(addr), .wdata_i(wdata), .ack_o(ack),
        .rdata_o(rdata), .access_ok_o(ok), .is_ctl_o(ctl),
        .redirect_o(redir));
    // small-package variant on the same bus, only its read data judged
    dmd_decoder #(.LARGE_PKG(0)) dut_small (.clk_i(clk_i),
        .nrst_i(nrst_i), .req_i(req), .we_i(we), .addr_i(addr),
        .wdata_i(wdata), .ack_o(), .rdata_o(rdata_s), .access_ok_o(),
        .is_ctl_o(), .redirect_o());
    task chk(input [7:0] e, input [7:0] g);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    end
    endtask
    task chk_bit(input e, input g);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    end
    endtask
    task close_out;
    begin
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // one access, answer flags judged while ack stands
    task xfer(input w, input [11:0] a, input [7:0] d);
    begin
        u_core.acc(w, a, d);
        chk_bit(1'b1, ack);
        chk_bit(1'b1, ok);
    end
    endtask
    task t_map;
    begin
        xfer(1'b1, 12'h000, 8'h5A);
        xfer(1'b0, 12'h000, 8'h00);
        chk(8'h5A, rdata);
        chk_bit(1'b0, ctl);
        chk_bit(1'b0, redir);
        xfer(1'b1, 12'hA5C, 8'h96);
        xfer(1'b0, 12'hA5C, 8'h00);
        chk(8'h96, rdata);
        xfer(1'b1, 12'hF80, 8'hC3);
        xfer(1'b0, 12'hF80, 8'h00);
        chk(8'hC3, rdata);
        chk_bit(1'b1, ctl);
        xfer(1'b1, 12'hF9C, 8'hA5);
        xfer(1'b0, 12'hF9C, 8'h00);
        chk(8'h00, rdata);
    end
    endtask
    task t_indirect;
    begin
        xfer(1'b1, 12'hFE9, 8'h10);
        xfer(1'b1, 12'hFEA, 8'h00);
        xfer(1'b1, 12'hFEF, 8'h3C);
        chk_bit(1'b1, redir);
        xfer(1'b0, 12'hFEE, 8'h00);
        chk(8'h3C, rdata);
        xfer(1'b1, 12'hFEF, 8'h77);
        xfer(1'b0, 12'h011, 8'h00);
        chk(8'h77, rdata);
        xfer(1'b1, 12'hFEC, 8'h21);
        xfer(1'b0, 12'hFED, 8'h00);
        chk(8'h21, rdata);
        xfer(1'b0, 12'hFEF, 8'h00);
        chk(8'h77, rdata);
        xfer(1'b1, 12'hFE8, 8'hFF);
        xfer(1'b0, 12'hFEB, 8'h00);
        chk(8'h3C, rdata);
        xfer(1'b0, 12'hFE9, 8'h00);
        chk(8'h11, rdata);
    end
    endtask
    task t_package;
    begin
        xfer(1'b1, 12'hF96, 8'h42);
        xfer(1'b0, 12'hF96, 8'h00);
        chk(8'h42, rdata);
        chk(8'h00, rdata_s);
        xfer(1'b1, 12'hF7A, 8'h66);
        xfer(1'b0, 12'hF7A, 8'h00);
        chk(8'h00, rdata);
        chk_bit(1'b0, ctl);
        xfer(1'b1, 12'hF77, 8'h99);
        xfer(1'b0, 12'hF77, 8'h00);
        chk(8'h99, rdata);
    end
    endtask
    task t_reset;
    begin
        @(negedge clk_i);
        nrst_i = 1'b0;
        @(negedge clk_i);
        nrst_i = 1'b1;
        xfer(1'b0, 12'h010, 8'h00);
        chk(8'h3C, rdata);
        xfer(1'b0, 12'hFEF, 8'h00);
        chk(8'h5A, rdata);
    end
    endtask
    initial
    begin
        repeat (10) @(negedge clk_i);
        nrst_i = 1'b1;
        t_map;
        t_indirect;
        t_package;
        t_reset;
        close_out;
    end
    initial
    begin
        #200000;
        err_count = err_count + 1;
        close_out;
    end
endmodule
bind dmd_decoder dmd_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .rdata_o(rdata_o),
    .ack_o(ack_o), .access_ok_o(access_ok_o), .is_ctl_o(is_ctl_o),
    .redirect_o(redirect_o));
